// file: cdcc_core.sv
/*
  Instruction core of a two-line, twenty-column character display: character store,
  glyph store, address counter, view shift, entry mode, display control and blink.
  Assumes a host port where every strobe is one cycle and synchronous to clock, and a
  display scanner that asks for one position and pixel row at a time.
*/
// Local design decisions: the strobed register port and the register offsets.
// Notes on behaviour
// - only addresses 00H-27H and 40H-67H are character store locations.
// - locations off screen still store and return written bytes.
// - unshifted view shows 00-13 on line one, 40-53 on line two.
// - a left shift moves every visible position one address higher, wrapping inside its bank.
// - a right shift moves one lower, wrapping inside its bank.
// - glyph store holds eight 5x8 glyphs at 00H-3FH, one lights a pixel.
// - glyph locations keep only their low five bits.
// - codes 00H-0FH pick glyphs; code bits 2..0 and row form the address.
// - clear fills the character store with 20H, homes counter and view.
// - clear also forces increment and leaves the glyph store alone.
// - home zeroes the counter and view shift, memories untouched.
// - decrement mode steps down; auto shift then shifts the view right.
// - increment mode steps up; auto shift then shifts the view left.
// - entry mode bit 0 enables auto shift, bit 1 picks direction.
// - no view shift after character reads or any glyph access.
// - display control bit 2 blanks or shows the screen.
// - display control bit 1 draws the cursor on pixel row eight.
// - bit 0 alternates the cursor character with a full block, 50% duty.
// - counter wraps 27H to 40H and 67H to 00H, reversed downward.
// - status read returns the counter in 6..0 and a zero wait flag.
// - glyph address set points data accesses at the glyph store; character address set, clear, home and move point them at the character store.
// - reset blanks the store, homes, increments, no shift, display off.
`default_nettype none

module cdcc_core #(
  parameter int unsigned BLINK_HALF = cdcc_pkg::BLINK_HALF_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     cmd_or_data_sel,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_strobe,
  input  wire logic                     rd_strobe,
  output logic      [7:0]               rd_data,
  input  wire cdcc_pkg::cdcc_scan_req_s scan_req,
  output cdcc_pkg::cdcc_scan_pix_s      scan_pix
);

  if (BLINK_HALF < 1) begin : g_bad_blink
    $error("BLINK_HALF must be at least one cycle");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]            char_mem [0:79];
  logic [4:0]            glyph_mem [0:63];
  logic [79:0]           blank_r;
  logic [6:0]            address_counter_r;
  logic [6:0]            address_counter_nxt;
  logic                  glyph_sel_r;
  logic                  glyph_sel_nxt;
  logic [5:0]            shift_r;
  logic [5:0]            shift_nxt;
  logic                  dir_inc_r;
  logic                  auto_shift_r;
  logic                  disp_on_r;
  logic                  cursor_on_r;
  logic                  blink_on_r;
  logic                  blink_phase_r;
  logic [31:0]           blink_cnt_r;
  logic [7:0]            rd_data_r;
  logic [7:0]            rd_data_nxt;
  cdcc_pkg::cdcc_scan_pix_s scan_pix_r;
  cdcc_pkg::cdcc_scan_pix_s scan_pix_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic char_ok(input logic [6:0] a);
    return (a[5:0] <= cdcc_pkg::BANK0_LAST[5:0]);
  endfunction : char_ok

  function automatic logic [6:0] char_index(input logic [6:0] a);
    return a[6] ? (7'(a[5:0]) + 7'(cdcc_pkg::BANK_DEPTH)) : 7'(a[5:0]);
  endfunction : char_index

  function automatic logic [6:0] char_step(input logic [6:0] a, input logic up);
    logic [6:0] n;
    n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (up && a == cdcc_pkg::BANK0_LAST) begin
      n = cdcc_pkg::BANK1_BASE;
    end else if (up && a == cdcc_pkg::BANK1_LAST) begin
      n = cdcc_pkg::HOME_ADDR;
    end else if (!up && a == cdcc_pkg::BANK1_BASE) begin
      n = cdcc_pkg::BANK0_LAST;
    end else if (!up && a == cdcc_pkg::HOME_ADDR) begin
      n = cdcc_pkg::BANK1_LAST;
    end
    return n;
  endfunction : char_step

  function automatic logic [5:0] shift_step(input logic [5:0] s, input logic left);
    logic [5:0] n;
    n = s;
    if (left) begin
      n = (s == 6'(cdcc_pkg::BANK_DEPTH - 1)) ? 6'h00 : 6'(s + 6'h01);
    end else begin
      n = (s == 6'h00) ? 6'(cdcc_pkg::BANK_DEPTH - 1) : 6'(s - 6'h01);
    end
    return n;
  endfunction : shift_step

  // unmapped store still answers; blanked cells read as space
  function automatic logic [7:0] char_read(input logic [6:0] a);
    logic [6:0] i;
    i = char_index(a);
    if (!char_ok(a) || blank_r[i]) begin
      return cdcc_pkg::SPACE_CODE;
    end
    return char_mem[i];
  endfunction : char_read

  //////////////////////////////////////////////////////////////////////////////
  // host decode
  cdcc_pkg::cdcc_instr_e ins;
  wire logic cmd_wr     = wr_strobe & ~cmd_or_data_sel;
  wire logic dat_wr     = wr_strobe & cmd_or_data_sel;
  wire logic stat_rd    = rd_strobe & ~cmd_or_data_sel;
  wire logic dat_rd     = rd_strobe & cmd_or_data_sel;
  wire logic dat_acc    = dat_wr | dat_rd;
  assign ins = cdcc_pkg::cdcc_decode(wr_data);
  wire logic is_clear   = cmd_wr && (ins == cdcc_pkg::INS_CLEAR);
  wire logic is_home    = cmd_wr && (ins == cdcc_pkg::INS_HOME);
  wire logic is_entry   = cmd_wr && (ins == cdcc_pkg::INS_ENTRY);
  wire logic is_disp    = cmd_wr && (ins == cdcc_pkg::INS_DISP);
  wire logic is_move    = cmd_wr && (ins == cdcc_pkg::INS_MOVE);
  wire logic is_gaddr   = cmd_wr && (ins == cdcc_pkg::INS_GLYPH_ADDR);
  wire logic is_caddr   = cmd_wr && (ins == cdcc_pkg::INS_CHAR_ADDR);
  wire logic move_right = wr_data[cdcc_pkg::MOVE_RIGHT_BIT];
  wire logic move_view  = wr_data[cdcc_pkg::MOVE_VIEW_BIT];

  wire logic [6:0] ac_idx     = char_index(address_counter_r);
  wire logic       ac_ok      = char_ok(address_counter_r);
  localparam logic [5:0] GLYPH_NEG = cdcc_pkg::GLYPH_LAST;
  wire logic [5:0] glyph_addr = address_counter_r[5:0];
  wire logic [6:0] ac_stepped = glyph_sel_r
                              ? {1'b0, 6'(glyph_addr + (dir_inc_r ? 6'h01 : GLYPH_NEG))}
                              : char_step(address_counter_r, dir_inc_r);

  //////////////////////////////////////////////////////////////////////////////
  // address counter and target store
  // clear and home zero the counter
  assign address_counter_nxt =
      (is_clear | is_home)      ? cdcc_pkg::HOME_ADDR :
      is_caddr                  ? wr_data[6:0] :
      is_gaddr                  ? {1'b0, wr_data[5:0]} :
      is_move                   ? char_step(address_counter_r, move_right) :
      dat_acc                   ? ac_stepped :
                                  address_counter_r;

  // glyph address set picks the glyph store; character address set, clear, home and move pick the character store
  assign glyph_sel_nxt = is_gaddr ? 1'b1 :
                         (is_clear | is_home | is_caddr | is_move) ? 1'b0 :
                         glyph_sel_r;

  //////////////////////////////////////////////////////////////////////////////
  // view shift
  // auto shift only on character writes, never on reads
  wire logic auto_step = dat_wr & ~glyph_sel_r & auto_shift_r;
  wire logic move_step = is_move & move_view;
  wire logic view_left = auto_step ? dir_inc_r : ~move_right;
  assign shift_nxt = (is_clear | is_home)     ? 6'h00 :
                     (auto_step | move_step)  ? shift_step(shift_r, view_left) :
                                                shift_r;

  //////////////////////////////////////////////////////////////////////////////
  // read data
  // status carries a zero wait flag
  // process form so that store updates retrigger the read path
  always_comb begin
    rd_data_nxt = 8'h00;
    if (stat_rd) begin
      rd_data_nxt = {1'b0, address_counter_r};
    end else if (dat_rd && glyph_sel_r) begin
      rd_data_nxt = {3'h0, glyph_mem[glyph_addr]};
    end else if (dat_rd) begin
      rd_data_nxt = char_read(address_counter_r);
    end
  end
  assign rd_data = rd_data_r;

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  // all updates land in one cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      address_counter_r <= cdcc_pkg::HOME_ADDR;
      glyph_sel_r       <= 1'b0;
      shift_r           <= 6'h00;
      dir_inc_r         <= cdcc_pkg::RST_DIR_INC;
      auto_shift_r      <= cdcc_pkg::RST_AUTO_SHIFT;
      disp_on_r         <= cdcc_pkg::RST_DISP_ON;
      cursor_on_r       <= cdcc_pkg::RST_CURSOR_ON;
      blink_on_r        <= cdcc_pkg::RST_BLINK_ON;
      blank_r           <= '1;
      rd_data_r         <= 8'h00;
    end else begin
      address_counter_r <= address_counter_nxt;
      glyph_sel_r       <= glyph_sel_nxt;
      shift_r           <= shift_nxt;
      rd_data_r         <= rd_data_nxt;
      if (is_entry) begin
        dir_inc_r    <= wr_data[cdcc_pkg::ENTRY_DIR_BIT];
        auto_shift_r <= wr_data[cdcc_pkg::ENTRY_SHIFT_BIT];
      end else if (is_clear) begin
        dir_inc_r <= 1'b1;
      end
      if (is_disp) begin
        disp_on_r   <= wr_data[cdcc_pkg::DISP_ON_BIT];
        cursor_on_r <= wr_data[cdcc_pkg::DISP_CURSOR_BIT];
        blink_on_r  <= wr_data[cdcc_pkg::DISP_BLINK_BIT];
      end
      // clear blanks every cell at once
      if (is_clear) begin
        blank_r <= '1;
      end else if (dat_wr && !glyph_sel_r && ac_ok) begin
        blank_r[ac_idx] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memories
  // any valid location stores host bytes
  always_ff @(posedge clock) begin
    if (dat_wr && !glyph_sel_r && ac_ok) begin
      char_mem[ac_idx] <= wr_data;
    end
  end

  // five bits kept per glyph location
  always_ff @(posedge clock) begin
    if (dat_wr && glyph_sel_r) begin
      glyph_mem[glyph_addr] <= wr_data[cdcc_pkg::GLYPH_BITS-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blink divider
  // half second phase
  wire logic blink_tick = (blink_cnt_r == BLINK_HALF - 1);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt_r   <= 32'h0;
      blink_phase_r <= 1'b0;
    end else begin
      blink_cnt_r <= blink_tick ? 32'h0 : 32'(blink_cnt_r + 32'h1);
      if (blink_tick) begin
        blink_phase_r <= ~blink_phase_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scan port
  // position to address through the shift offset
  wire logic [6:0] view_sum  = 7'(scan_req.col) + 7'(shift_r);
  wire logic [6:0] view_off  = (view_sum >= 7'(cdcc_pkg::BANK_DEPTH))
                             ? 7'(view_sum - 7'(cdcc_pkg::BANK_DEPTH)) : view_sum;
  wire logic [6:0] view_addr = scan_req.line ? (cdcc_pkg::BANK1_BASE | view_off) : view_off;
  logic       [7:0] view_code;
  always_comb begin
    view_code = char_read(view_addr);
  end
  wire logic       at_cursor = !glyph_sel_r && (view_addr == address_counter_r);

  always_comb begin
    scan_pix_nxt = '0;
    scan_pix_nxt.code = view_code;
    scan_pix_nxt.glyph_row  = glyph_mem[{view_code[2:0], scan_req.row}];
    scan_pix_nxt.user       = (view_code[7:4] == cdcc_pkg::USER_CODE_HI);
    scan_pix_nxt.blank      = ~disp_on_r;
    scan_pix_nxt.cursor_row = cursor_on_r && at_cursor && (scan_req.row == cdcc_pkg::CURSOR_ROW);
    scan_pix_nxt.blink_full = blink_on_r && at_cursor && blink_phase_r;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scan_pix_r <= '0;
    end else begin
      scan_pix_r <= scan_pix_nxt;
    end
  end
  assign scan_pix = scan_pix_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_status_read_ac: assert property (
    stat_rd |=> rd_data == {1'b0, $past(address_counter_r)})
    else $error("status read did not return the address counter");

  chk_clear_defaults: assert property (
    is_clear |=> address_counter_r == 7'h00 && shift_r == 6'h00 && dir_inc_r && !glyph_sel_r)
    else $error("clear did not home counter, view and direction");

  chk_home_keeps_dir: assert property (
    is_home |=> address_counter_r == 7'h00 && shift_r == 6'h00 && dir_inc_r == $past(dir_inc_r))
    else $error("home wrong");

  chk_up_bank_wrap: assert property (
    dat_acc && !glyph_sel_r && dir_inc_r && address_counter_r == 7'h27
    |=> address_counter_r == 7'h40)
    else $error("counter did not wrap 27H to 40H");

  chk_down_bank_wrap: assert property (
    dat_acc && !glyph_sel_r && !dir_inc_r && address_counter_r == 7'h00
    |=> address_counter_r == 7'h67)
    else $error("counter did not wrap 00H to 67H");

  chk_read_no_shift: assert property (
    (dat_rd || (dat_wr && glyph_sel_r)) && !cmd_wr |=> $stable(shift_r))
    else $error("view shifted on read or glyph access");

  chk_left_shift_step: assert property (
    dat_wr && !glyph_sel_r && auto_shift_r && dir_inc_r && shift_r == 6'd39
    |=> shift_r == 6'd0)
    else $error("left shift did not wrap");

  chk_blank_follows: assert property (
    !disp_on_r && $stable(disp_on_r) |=> scan_pix.blank)
    else $error("display off did not blank");

  chk_blink_divider: assert property (
    blink_tick |=> blink_cnt_r == 32'h0 ##0 $changed(blink_phase_r))
    else $error("blink phase did not toggle on the divider");

  chk_entry_mode_set: assert property (
    is_entry |=> dir_inc_r == $past(wr_data[1]) && auto_shift_r == $past(wr_data[0]))
    else $error("entry mode bits not taken");

  chk_disp_keeps_ac: assert property (
    is_disp |=> address_counter_r == $past(address_counter_r))
    else $error("display control moved the address counter");

  chk_cursor_needs_on: assert property (
    scan_pix.cursor_row |-> $past(cursor_on_r) && $past(scan_req.row) == cdcc_pkg::CURSOR_ROW)
    else $error("cursor drawn while off or on the wrong row");

  chk_move_view_right: assert property (
    is_move && move_view && move_right && shift_r == 6'd0 |=> shift_r == 6'd39)
    else $error("right view shift did not wrap");

  cov_clear: cover property (is_clear ##1 dat_wr);
  cov_move_view: cover property (is_move && move_view);
  cov_glyph_write: cover property (is_gaddr ##1 dat_wr ##1 dat_rd);
  cov_auto_shift: cover property (auto_step && shift_r == 6'd0);
  cov_wrap_up: cover property (dat_wr && address_counter_r == 7'h67);

endmodule : cdcc_core

`default_nettype wire

// file: cdcc_pkg.sv
/*
  Shared constants, instruction decode and scan carriers for the character display
  command core.
  Assumes a single 100 MHz clock. No other package is needed.
*/
`default_nettype none

package cdcc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int BLINK_HALF_NS     = 500_000_000;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // character store and glyph store layout
  localparam int         BANK_DEPTH   = 40;
  localparam int         VIEW_COLS    = 20;
  localparam int         GLYPH_BITS   = 5;
  localparam logic [6:0] BANK0_LAST   = 7'h27;
  localparam logic [6:0] BANK1_BASE   = 7'h40;
  localparam logic [6:0] BANK1_LAST   = 7'h67;
  localparam logic [6:0] HOME_ADDR    = 7'h00;
  localparam logic [5:0] GLYPH_LAST   = 6'h3F;
  localparam logic [7:0] SPACE_CODE   = 8'h20;
  localparam logic [2:0] CURSOR_ROW   = 3'h7;
  localparam logic [3:0] USER_CODE_HI = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic RST_DIR_INC    = 1'b1;
  localparam logic RST_AUTO_SHIFT = 1'b0;
  localparam logic RST_DISP_ON    = 1'b0;
  localparam logic RST_CURSOR_ON  = 1'b0;
  localparam logic RST_BLINK_ON   = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // instruction field positions
  localparam int ENTRY_DIR_BIT   = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT     = 2;
  localparam int DISP_CURSOR_BIT = 1;
  localparam int DISP_BLINK_BIT  = 0;
  localparam int MOVE_VIEW_BIT   = 3;
  localparam int MOVE_RIGHT_BIT  = 2;

  typedef enum logic [8:0] {
    INS_NONE       = 9'h001,
    INS_CLEAR      = 9'h002,
    INS_HOME       = 9'h004,
    INS_ENTRY      = 9'h008,
    INS_DISP       = 9'h010,
    INS_MOVE       = 9'h020,
    INS_FUNC       = 9'h040,
    INS_GLYPH_ADDR = 9'h080,
    INS_CHAR_ADDR  = 9'h100
  } cdcc_instr_e;

  typedef struct packed {
    logic       line;
    logic [4:0] col;
    logic [2:0] row;
  } cdcc_scan_req_s;

  typedef struct packed {
    logic [7:0] code;
    logic [4:0] glyph_row;
    logic       user;
    logic       blank;
    logic       cursor_row;
    logic       blink_full;
  } cdcc_scan_pix_s;

  // highest set bit picks the instruction
  function automatic cdcc_instr_e cdcc_decode(input logic [7:0] b);
    cdcc_instr_e k;
    k = INS_NONE;
    if (b[7]) begin
      k = INS_CHAR_ADDR;
    end else if (b[6]) begin
      k = INS_GLYPH_ADDR;
    end else if (b[5]) begin
      k = INS_FUNC;
    end else if (b[4]) begin
      k = INS_MOVE;
    end else if (b[3]) begin
      k = INS_DISP;
    end else if (b[2]) begin
      k = INS_ENTRY;
    end else if (b[1]) begin
      k = INS_HOME;
    end else if (b[0]) begin
      k = INS_CLEAR;
    end
    return k;
  endfunction : cdcc_decode

endpackage : cdcc_pkg

`default_nettype wire

// file: cdcc_host_model.sv
/*
  Host model: issues one-byte instruction and data transfers into the core.
  Assumes the core answers a read in the cycle after the strobe and never stalls.
*/
`default_nettype none

module cdcc_host_model (
  input  wire logic       clock,
  output logic            cmd_or_data_sel,
  output logic      [7:0] wr_data,
  output logic            wr_strobe,
  output logic            rd_strobe,
  input  wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_or_data_sel = 1'b0;
    wr_data         = 8'h00;
    wr_strobe       = 1'b0;
    rd_strobe       = 1'b0;
  end

  task automatic put_byte(input logic sel, input logic [7:0] b);
    @(posedge clock);
    cmd_or_data_sel <= sel;
    wr_data         <= b;
    wr_strobe       <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wr_data   <= ~b;
  endtask : put_byte

  task automatic get_byte(input logic sel, output logic [7:0] q);
    @(posedge clock);
    cmd_or_data_sel <= sel;
    rd_strobe       <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    q = rd_data;
  endtask : get_byte

endmodule : cdcc_host_model

`default_nettype wire

// file: cdcc_core_test.sv
/*
  Self-checking bench for the display command core.
  Assumes the host model beside it and a short blink divider.
*/
`default_nettype none

module cdcc_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clock;
  logic                     reset_n;
  logic                     cmd_or_data_sel;
  logic [7:0]               wr_data;
  logic                     wr_strobe;
  logic                     rd_strobe;
  logic [7:0]               rd_data;
  cdcc_pkg::cdcc_scan_req_s scan_req;
  cdcc_pkg::cdcc_scan_pix_s scan_pix;
  cdcc_pkg::cdcc_scan_pix_s pix;
  logic [7:0]               q;
  int                       error_cnt;
  int                       total_checks;
  int                       n;

  cdcc_core #(.BLINK_HALF(4)) cdcc_core_inst (
    .clock(clock), .reset_n(reset_n), .cmd_or_data_sel(cmd_or_data_sel),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .scan_req(scan_req), .scan_pix(scan_pix)
  );

  cdcc_host_model cdcc_host_model_inst (
    .clock(clock), .cmd_or_data_sel(cmd_or_data_sel), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wi(input logic [7:0] b);
    cdcc_host_model_inst.put_byte(1'b0, b);
  endtask : wi

  task automatic wd(input logic [7:0] b);
    cdcc_host_model_inst.put_byte(1'b1, b);
  endtask : wd

  task automatic wr_at(input logic [7:0] a, input logic [7:0] b);
    wi(8'h80 | a);
    wd(b);
  endtask : wr_at

  task automatic stat(input logic [7:0] exp);
    cdcc_host_model_inst.get_byte(1'b0, q);
    chk("status", exp, q);
  endtask : stat

  task automatic dat(input logic [7:0] exp);
    cdcc_host_model_inst.get_byte(1'b1, q);
    chk("data", exp, q);
  endtask : dat

  task automatic look(input logic ln, input logic [4:0] col, input logic [2:0] row);
    @(posedge clock);
    scan_req <= '{line: ln, col: col, row: row};
    @(posedge clock);
    #1;
    pix = scan_pix;
  endtask : look

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    #200_000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt    = 0;
    total_checks = 0;
    reset_n      = 1'b0;
    scan_req     = '0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    stat(8'h00);
    dat(8'h20);
    stat(8'h01);
    wr_at(8'h00, 8'h41);
    wd(8'h42);
    stat(8'h02);
    wi(8'h80);
    dat(8'h41);
    look(1'b0, 5'h01, 3'h0);
    chk("code", 8'h42, pix.code);
    wr_at(8'h27, 8'h27);
    stat(8'h40);
    wr_at(8'h67, 8'h67);
    stat(8'h00);
    wr_at(8'h20, 8'h5A);
    wi(8'hA0);
    dat(8'h5A);
    wr_at(8'h28, 8'h77);
    wi(8'hA8);
    dat(8'h20);
    wi(8'h04);
    wr_at(8'h40, 8'h66);
    stat(8'h27);
    wr_at(8'h00, 8'h33);
    stat(8'h67);
    wi(8'h48);
    wd(8'hFF);
    stat(8'h07);
    wi(8'h48);
    dat(8'h1F);
    wi(8'h06);
    wr_at(8'h02, 8'h09);
    wd(8'h01);
    wi(8'h02);
    look(1'b0, 5'h02, 3'h0);
    chk("user", 8'h01, {7'h00, pix.user});
    chk("glyph", 8'h1F, {3'h0, pix.glyph_row});
    look(1'b0, 5'h03, 3'h0);
    chk("glyph", 8'h1F, {3'h0, pix.glyph_row});
    look(1'b0, 5'h01, 3'h0);
    chk("user", 8'h00, {7'h00, pix.user});
    wi(8'h07);
    wr_at(8'h00, 8'h11);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h42, pix.code);
    look(1'b1, 5'h00, 3'h0);
    chk("code", 8'h20, pix.code);
    wi(8'h48);
    wd(8'h1F);
    wi(8'h80);
    dat(8'h11);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h42, pix.code);
    wi(8'h03);
    stat(8'h00);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h11, pix.code);
    look(1'b1, 5'h00, 3'h0);
    chk("code", 8'h66, pix.code);
    wi(8'h05);
    wr_at(8'h01, 8'h22);
    stat(8'h00);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h27, pix.code);
    look(1'b1, 5'h00, 3'h0);
    chk("code", 8'h67, pix.code);
    look(1'b0, 5'h01, 3'h0);
    chk("code", 8'h11, pix.code);
    wi(8'h02);
    wi(8'h1C);
    stat(8'h01);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h27, pix.code);
    wi(8'h18);
    stat(8'h00);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h11, pix.code);
    wi(8'h0C);
    look(1'b0, 5'h00, 3'h0);
    chk("blank", 8'h00, {7'h00, pix.blank});
    wi(8'h08);
    look(1'b0, 5'h00, 3'h0);
    chk("blank", 8'h01, {7'h00, pix.blank});
    stat(8'h00);
    wi(8'h0E);
    wi(8'h85);
    look(1'b0, 5'h05, 3'h7);
    chk("cursor", 8'h01, {7'h00, pix.cursor_row});
    chk("blink", 8'h00, {7'h00, pix.blink_full});
    look(1'b0, 5'h05, 3'h6);
    chk("cursor", 8'h00, {7'h00, pix.cursor_row});
    look(1'b0, 5'h04, 3'h7);
    chk("cursor", 8'h00, {7'h00, pix.cursor_row});
    wi(8'h0D);
    look(1'b0, 5'h05, 3'h0);
    n = 0;
    repeat (16) begin
      @(posedge clock);
      #1;
      if (scan_pix.blink_full === 1'b1) begin
        n++;
      end
    end
    chk("blink", 8'h08, n[7:0]);
    wi(8'h04);
    wi(8'h01);
    stat(8'h00);
    dat(8'h20);
    stat(8'h01);
    wi(8'hC0);
    dat(8'h20);
    wi(8'h48);
    dat(8'h1F);
    wr_at(8'h00, 8'h5A);
    look(1'b0, 5'h00, 3'h0);
    chk("code", 8'h5A, pix.code);
    end_of_test();
  end

endmodule : cdcc_core_test

`default_nettype wire
